// file: logic/lvr_pkg.sv
// constants, register map and types of the undervoltage reset block
// assumes a single pclk domain and a synchronous slow-oscillator tick
package lvr_pkg;

    // apb register byte addresses
    localparam logic [7:0] LVR_ADDR_CONFIG = 8'h00;
    localparam logic [7:0] LVR_ADDR_CAUSE = 8'h04;
    localparam logic [7:0] LVR_ADDR_STATUS = 8'h08;
    localparam logic [7:0] LVR_ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] LVR_ADDR_IRQ_CLR = 8'h10;
    localparam logic [7:0] LVR_ADDR_IRQ_EN = 8'h14;

    // threshold select codes
    localparam logic [7:0] LVR_CODE_1V7 = 8'h5A;
    localparam logic [7:0] LVR_CODE_OFF = 8'hA5;
    localparam logic [7:0] LVR_CONFIG_RESET = 8'h5A;

    // mode_and_reset_cause field positions
    localparam int LVR_BIT_SYSCLK_KEEP = 7;
    localparam int LVR_BIT_PIN_SEL = 3;
    localparam int LVR_BIT_LOW_V = 2;
    localparam int LVR_BIT_BAD_CODE = 1;
    localparam int LVR_BIT_WDT_CODE = 0;

    // status register field positions
    localparam int LVR_BIT_TIMEOUT = 0;
    localparam int LVR_BIT_PDOWN = 1;

    // interrupt event bit positions
    localparam int LVR_IRQ_LOW_V = 0;
    localparam int LVR_IRQ_BAD_CODE = 1;
    localparam int LVR_IRQ_WDT = 2;
    localparam int LVR_IRQ_W = 3;

    // counts in slow oscillator ticks and pclk cycles
    localparam logic [3:0] LVR_RESET_DELAY_TICKS = 4'h2;
    localparam logic [3:0] LVR_MIN_TICKS_DEF = 4'h4;
    localparam logic [7:0] LVR_HOLD_CYCLES_DEF = 8'h10;

    typedef enum logic [1:0] {
        LVR_MODE_NORMAL = 2'b00,
        LVR_MODE_SLOW = 2'b01,
        LVR_MODE_IDLE = 2'b10,
        LVR_MODE_SLEEP = 2'b11
    } lvr_mode_t;

    typedef enum logic [1:0] {
        LVR_ST_IDLE = 2'b00,
        LVR_ST_QUAL = 2'b01,
        LVR_ST_DELAY = 2'b10,
        LVR_ST_RESET = 2'b11
    } lvr_state_t;

    typedef enum logic [1:0] {
        LVR_CAUSE_LOW_V = 2'b00,
        LVR_CAUSE_BAD_CODE = 2'b01,
        LVR_CAUSE_WDT = 2'b10
    } lvr_cause_t;

    typedef struct packed {
        logic pin_sel;
        logic low_v;
        logic bad_code;
        logic wdt_code;
    } lvr_flags_t;

endpackage

// file: logic/lvr_supervisor.sv
// undervoltage supervisor, reset generator and reset cause flags
// assumes apb master on pclk; detector, modes and events synchronous
// except lv_detect, which is asynchronous and synchronised here
`timescale 1ns/1ns
`default_nettype none

module lvr_supervisor
    import lvr_pkg::*;
#(
    parameter logic [3:0] MIN_TICKS = LVR_MIN_TICKS_DEF,
    parameter logic [7:0] HOLD_CYCLES = LVR_HOLD_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slow_osc_tick,
    input wire logic lv_detect,
    input wire lvr_mode_t power_mode,
    input wire logic wdt_timeout,
    input wire logic halt_event,
    input wire logic pin_select_bad_event,
    input wire logic watchdog_code_bad_event,
    output logic device_reset,
    output logic pc_sp_clear,
    output logic wdt_count_en,
    output logic supervise_on,
    output logic irq
);

    function automatic logic low_power(input lvr_mode_t m);
        low_power = (m == LVR_MODE_IDLE) || (m == LVR_MODE_SLEEP);
    endfunction

    lvr_state_t state_q, state_d;
    lvr_cause_t cause_q, cause_d;
    lvr_flags_t flags_q, flags_d;
    logic [7:0] config_q, config_d;
    logic sysclk_keep_q, sysclk_keep_d;
    logic timeout_q, timeout_d;
    logic pdown_q, pdown_d;
    logic [3:0] tick_cnt_q, tick_cnt_d;
    logic [7:0] hold_cnt_q, hold_cnt_d;
    logic lv_meta_q, lv_sync_q;
    logic [LVR_IRQ_W-1:0] irq_stat_q, irq_stat_d;
    logic [LVR_IRQ_W-1:0] irq_en_q, irq_en_d;
    logic [LVR_IRQ_W-1:0] events;
    logic [31:0] prdata_q, rd_mux;
    logic pready_q, pslverr_q, device_reset_q, pc_sp_clear_q;
    logic wdt_count_en_q, supervise_on_q, irq_q;

    // bus decode
    wire access = psel && penable && !pready_q;
    wire done = psel && penable && pready_q;
    wire wr = done && pwrite;
    wire hit_config = (paddr == LVR_ADDR_CONFIG);
    wire hit_cause = (paddr == LVR_ADDR_CAUSE);
    wire hit_status = (paddr == LVR_ADDR_STATUS);
    wire hit_istat = (paddr == LVR_ADDR_IRQ_STAT);
    wire hit_iclr = (paddr == LVR_ADDR_IRQ_CLR);
    wire hit_ien = (paddr == LVR_ADDR_IRQ_EN);
    wire mapped = hit_config || hit_cause || hit_status || hit_istat
                  || hit_iclr || hit_ien;
    // status is read-only, the clear register write-only
    wire bad_access = !mapped || (pwrite && (hit_status || hit_istat))
                      || (!pwrite && hit_iclr);
    wire wr_config = wr && hit_config && !bad_access;
    wire wr_cause = wr && hit_cause && !bad_access;
    wire wr_iclr = wr && hit_iclr && !bad_access;
    wire wr_ien = wr && hit_ien && !bad_access;

    // supervision decode
    wire code_valid = (config_q == LVR_CODE_1V7) ||
                      (config_q == LVR_CODE_OFF);
    wire code_bad = !code_valid;
    wire supervise = (config_q == LVR_CODE_1V7)
                     && !low_power(power_mode);
    wire lv_seen = lv_sync_q && supervise;
    wire wdt_run = wdt_timeout && !low_power(power_mode);
    wire wdt_halt = wdt_timeout && low_power(power_mode);
    wire idle_st = (state_q == LVR_ST_IDLE);
    wire start_wdt = idle_st && wdt_run;
    wire start_bad = idle_st && !wdt_run && code_bad;
    wire start_qual = idle_st && !wdt_run && code_valid && lv_seen;
    wire qual_done = (state_q == LVR_ST_QUAL) && lv_seen && slow_osc_tick
                     && (tick_cnt_q == MIN_TICKS - 4'h1);
    // third tick ends the delay: entry phase is arbitrary for bad code
    // and watchdog, so the wait spans two to three slow periods
    wire delay_done = (state_q == LVR_ST_DELAY) && slow_osc_tick
                      && (tick_cnt_q == LVR_RESET_DELAY_TICKS);
    wire fire_lv = delay_done && (cause_q == LVR_CAUSE_LOW_V);
    wire fire_bad = delay_done && (cause_q == LVR_CAUSE_BAD_CODE);

    // reset sequencing
    always_comb begin
        state_d = state_q;
        cause_d = cause_q;
        tick_cnt_d = tick_cnt_q;
        hold_cnt_d = hold_cnt_q;
        case (state_q)
            LVR_ST_IDLE: begin
                tick_cnt_d = 4'h0;
                if (start_wdt) begin
                    state_d = LVR_ST_DELAY;
                    cause_d = LVR_CAUSE_WDT;
                end else if (start_bad) begin
                    state_d = LVR_ST_DELAY;
                    cause_d = LVR_CAUSE_BAD_CODE;
                end else if (start_qual) begin
                    state_d = LVR_ST_QUAL;
                    cause_d = LVR_CAUSE_LOW_V;
                end
            end
            LVR_ST_QUAL: begin
                // a dip that ends early never reaches the delay stage
                if (!lv_seen) begin
                    state_d = LVR_ST_IDLE;
                end else if (qual_done) begin
                    state_d = LVR_ST_DELAY;
                    tick_cnt_d = 4'h0;
                end else if (slow_osc_tick) begin
                    tick_cnt_d = tick_cnt_q + 4'h1;
                end
            end
            LVR_ST_DELAY: begin
                // counts ticks from entry until delay_done
                if (delay_done) begin
                    state_d = LVR_ST_RESET;
                    hold_cnt_d = 8'h00;
                end else if (slow_osc_tick) begin
                    tick_cnt_d = tick_cnt_q + 4'h1;
                end
            end
            LVR_ST_RESET: begin
                // fixed hold length; new events wait for the idle stage
                if (hold_cnt_q == HOLD_CYCLES - 8'h01) begin
                    state_d = LVR_ST_IDLE;
                end else begin
                    hold_cnt_d = hold_cnt_q + 8'h01;
                end
            end
            default: begin
                state_d = LVR_ST_RESET;
                hold_cnt_d = 8'h00;
            end
        endcase
    end

    // register contents; hardware set wins over software clear
    always_comb begin
        config_d = config_q;
        if (wr_config) begin
            config_d = pwdata[7:0];
        end
        if (fire_bad) begin
            config_d = LVR_CONFIG_RESET;
        end
        // a low-voltage reset does not touch config_d here
        sysclk_keep_d = sysclk_keep_q;
        flags_d = flags_q;
        if (wr_cause) begin
            sysclk_keep_d = pwdata[LVR_BIT_SYSCLK_KEEP];
            flags_d.pin_sel = flags_q.pin_sel && pwdata[LVR_BIT_PIN_SEL];
            flags_d.low_v = flags_q.low_v && pwdata[LVR_BIT_LOW_V];
            flags_d.bad_code = flags_q.bad_code
                               && pwdata[LVR_BIT_BAD_CODE];
            flags_d.wdt_code = flags_q.wdt_code && pwdata[LVR_BIT_WDT_CODE];
        end
        if (fire_lv) begin
            flags_d.low_v = 1'b1;
        end
        if (start_bad) begin
            flags_d.bad_code = 1'b1;
        end
        if (pin_select_bad_event) begin
            flags_d.pin_sel = 1'b1;
        end
        if (watchdog_code_bad_event) begin
            flags_d.wdt_code = 1'b1;
        end
        // low-voltage resets leave both flags alone; presetn clears them
        timeout_d = timeout_q || wdt_timeout;
        pdown_d = pdown_q || wdt_halt || halt_event;
    end

    // one-cycle event pulses; the sticky status keeps them
    assign events[LVR_IRQ_LOW_V] = fire_lv;
    assign events[LVR_IRQ_BAD_CODE] = start_bad;
    assign events[LVR_IRQ_WDT] = wdt_timeout;

    always_comb begin
        irq_en_d = irq_en_q;
        if (wr_ien) begin
            irq_en_d = pwdata[LVR_IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_q;
        if (wr_iclr) begin
            irq_stat_d = irq_stat_q & ~pwdata[LVR_IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_d | events;
    end

    // read mux; unimplemented bits 6 to 4 stay zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_config) begin
            rd_mux[7:0] = config_q;
        end
        if (hit_cause) begin
            rd_mux[LVR_BIT_SYSCLK_KEEP] = sysclk_keep_q;
            rd_mux[3:0] = flags_q;
        end
        if (hit_status) begin
            rd_mux[LVR_BIT_TIMEOUT] = timeout_q;
            rd_mux[LVR_BIT_PDOWN] = pdown_q;
        end
        if (hit_istat) begin
            rd_mux[LVR_IRQ_W-1:0] = irq_stat_q;
        end
        if (hit_ien) begin
            rd_mux[LVR_IRQ_W-1:0] = irq_en_q;
        end
    end

    // comparator synchroniser
    // comparator is asynchronous to pclk; only the second stage
    // feeds the qualifier, so a metastable first stage never spreads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_meta_q <= 1'b0;
            lv_sync_q <= 1'b0;
        end else begin
            lv_meta_q <= lv_detect;
            lv_sync_q <= lv_meta_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // power-on starts in the hold stage
            state_q <= LVR_ST_RESET;
            cause_q <= LVR_CAUSE_LOW_V;
            tick_cnt_q <= 4'h0;
            hold_cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cause_q <= cause_d;
            tick_cnt_q <= tick_cnt_d;
            hold_cnt_q <= hold_cnt_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_q <= LVR_CONFIG_RESET;
            sysclk_keep_q <= 1'b0;
            flags_q <= '0;
            timeout_q <= 1'b0;
            pdown_q <= 1'b0;
            irq_stat_q <= '0;
            irq_en_q <= '0;
        end else begin
            config_q <= config_d;
            sysclk_keep_q <= sysclk_keep_d;
            flags_q <= flags_d;
            timeout_q <= timeout_d;
            pdown_q <= pdown_d;
            irq_stat_q <= irq_stat_d;
            irq_en_q <= irq_en_d;
        end
    end

    // one wait state: response registered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access;
            pslverr_q <= access && bad_access;
            if (access && !pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // core-facing outputs; device_reset clears PC, stops timers,
    // disables interrupts, makes ports inputs, sets SP to stack top
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_reset_q <= 1'b1;
            pc_sp_clear_q <= 1'b0;
            wdt_count_en_q <= 1'b0;
            supervise_on_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            device_reset_q <= (state_d == LVR_ST_RESET);
            pc_sp_clear_q <= wdt_halt;
            wdt_count_en_q <= (state_d != LVR_ST_RESET);
            supervise_on_q <= supervise;
            irq_q <= |(irq_stat_d & irq_en_d);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign device_reset = device_reset_q;
    assign pc_sp_clear = pc_sp_clear_q;
    assign wdt_count_en = wdt_count_en_q;
    assign supervise_on = supervise_on_q;
    assign irq = irq_q;

endmodule

`default_nettype wire

// file: testbench/lvr_supervisor_assertions.sv
// checker for the undervoltage reset block, bound to its top module
// assumes one pclk domain with presetn as its only reset
`timescale 1ns/1ns
`default_nettype none
module lvr_supervisor_assertions
    import lvr_pkg::*;
#(
    parameter logic [3:0] MIN_TICKS = LVR_MIN_TICKS_DEF,
    parameter logic [7:0] HOLD_CYCLES = LVR_HOLD_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire lvr_mode_t power_mode,
    input wire logic wdt_timeout,
    input wire logic device_reset,
    input wire logic pc_sp_clear,
    input wire logic wdt_count_en,
    input wire logic supervise_on
);
    logic [7:0] hold_q;
    logic cfg_bad;
    assign cfg_bad = psel && penable && pready && pwrite
        && paddr == LVR_ADDR_CONFIG && pwdata[7:0] != LVR_CODE_1V7
        && pwdata[7:0] != LVR_CODE_OFF;
    // counts sampled reset cycles, checked when the reset drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 8'h00;
        end else begin
            hold_q <= device_reset ? hold_q + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_count_en_inverse: assert property (wdt_count_en == !device_reset)
        else $error("watchdog enable not inverse of reset");
    a_hold_length: assert property (
        $fell(device_reset) |-> hold_q == HOLD_CYCLES)
        else $error("reset held for wrong length");
    a_bad_code_reset: assert property (cfg_bad |-> ##[1:40] device_reset)
        else $error("bad threshold code gave no reset");
    a_pready_wait: assert property (
        psel && $rose(penable) |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    a_pready_single: assert property (pready |=> !pready)
        else $error("apb ready longer than one cycle");
    a_pcsp_cause: assert property (
        pc_sp_clear |-> $past(wdt_timeout) && $past(power_mode[1]))
        else $error("pc and sp cleared without low power timeout");
    a_sleep_clear: assert property (
        wdt_timeout && power_mode[1] && !device_reset |=> pc_sp_clear)
        else $error("low power timeout did not clear pc and sp");
    a_supervise_off: assert property (power_mode[1] |=> !supervise_on)
        else $error("supervision active in idle or sleep");
endmodule
bind lvr_supervisor lvr_supervisor_assertions #(
    .MIN_TICKS(MIN_TICKS), .HOLD_CYCLES(HOLD_CYCLES)
) i_lvr_supervisor_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .power_mode(power_mode), .wdt_timeout(wdt_timeout),
    .device_reset(device_reset), .pc_sp_clear(pc_sp_clear),
    .wdt_count_en(wdt_count_en), .supervise_on(supervise_on)
);
`default_nettype wire

// file: testbench/lvr_supervisor_test.sv
// self-checking bench of the undervoltage reset block over apb
// assumes one slow tick every four pclk cycles, short hold counts
`timescale 1ns/1ns
`default_nettype none
module lvr_supervisor_test;
    import lvr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic slow_osc_tick, lv_detect, wdt_timeout, halt_event;
    logic pin_bad, wcode_bad, device_reset, pc_sp_clear;
    logic wdt_count_en, supervise_on, err;
    logic [1:0] tdiv;
    lvr_mode_t power_mode;
    int mismatches, check_count, cyc;
    lvr_supervisor #(.MIN_TICKS(4'h2), .HOLD_CYCLES(8'h04)) i_lvr_supervisor (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slow_osc_tick(slow_osc_tick),
        .lv_detect(lv_detect), .power_mode(power_mode),
        .wdt_timeout(wdt_timeout), .halt_event(halt_event),
        .pin_select_bad_event(pin_bad), .watchdog_code_bad_event(wcode_bad),
        .device_reset(device_reset), .pc_sp_clear(pc_sp_clear),
        .wdt_count_en(wdt_count_en), .supervise_on(supervise_on), .irq(irq)
    );
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // whole run needs a few hundred cycles
    always @(posedge pclk) begin
        cyc++;
        tdiv <= tdiv + 2'd1;
        slow_osc_tick <= (tdiv == 2'd3);
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // pready ends this wait; the cycle ceiling stops a hang
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: a following call never re-drives psel in this step
        @(posedge pclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(rd, exp);
    endtask
    // exp 0: no reset may appear inside the window
    task automatic wait_rst(input logic exp);
        int n;
        n = 0;
        while (device_reset !== 1'b1 && n < 60) begin
            n++;
            @(posedge pclk);
        end
        lv_detect <= 1'b0;
        check(device_reset, exp);
        while (device_reset === 1'b1) @(posedge pclk);
    endtask
    task automatic wdt_pulse();
        wdt_timeout <= 1'b1;
        @(posedge pclk);
        wdt_timeout <= 1'b0;
        @(posedge pclk);
    endtask
    initial begin
        {psel, penable, pwrite, lv_detect, wdt_timeout, halt_event} = '0;
        {pin_bad, wcode_bad, slow_osc_tick, tdiv, paddr, pwdata} = '0;
        {mismatches, check_count, cyc} = '0;
        power_mode = LVR_MODE_NORMAL;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        wait_rst(1'b1);
        rd_chk(LVR_ADDR_CONFIG, {24'h0, LVR_CONFIG_RESET});
        rd_chk(LVR_ADDR_STATUS, 32'h00000000);
        apb(1'b1, LVR_ADDR_IRQ_EN, 32'h00000007);
        rd_chk(LVR_ADDR_IRQ_EN, 32'h00000007);
        $display("reset values done");
        apb(1'b1, LVR_ADDR_CONFIG, {24'h0, LVR_CODE_OFF});
        lv_detect <= 1'b1;
        wait_rst(1'b0);
        check(supervise_on, 1'b0);
        apb(1'b1, LVR_ADDR_CONFIG, {24'h0, LVR_CODE_1V7});
        power_mode <= LVR_MODE_IDLE;
        lv_detect <= 1'b1;
        wait_rst(1'b0);
        power_mode <= LVR_MODE_NORMAL;
        repeat (4) @(posedge pclk);
        lv_detect <= 1'b1;
        @(posedge pclk);
        lv_detect <= 1'b0;
        wait_rst(1'b0);
        $display("ignored low supply done");
        lv_detect <= 1'b1;
        wait_rst(1'b1);
        check(irq, 1'b1);
        rd_chk(LVR_ADDR_CAUSE, 32'h00000004);
        rd_chk(LVR_ADDR_CONFIG, {24'h0, LVR_CODE_1V7});
        apb(1'b1, LVR_ADDR_IRQ_CLR, 32'h00000007);
        @(posedge pclk);
        check(irq, 1'b0);
        apb(1'b1, LVR_ADDR_CAUSE, 32'h00000000);
        apb(1'b1, LVR_ADDR_CAUSE, 32'h000000FF);
        rd_chk(LVR_ADDR_CAUSE, 32'h00000080);
        $display("low voltage reset done");
        apb(1'b1, LVR_ADDR_CONFIG, 32'h00000033);
        wait_rst(1'b1);
        rd_chk(LVR_ADDR_CONFIG, {24'h0, LVR_CONFIG_RESET});
        rd_chk(LVR_ADDR_CAUSE, 32'h00000082);
        rd_chk(LVR_ADDR_IRQ_STAT, 32'h00000002);
        $display("bad code done");
        power_mode <= LVR_MODE_SLOW;
        wdt_pulse();
        wait_rst(1'b1);
        rd_chk(LVR_ADDR_STATUS, 32'h00000001);
        power_mode <= LVR_MODE_SLEEP;
        @(posedge pclk);
        wdt_timeout <= 1'b1;
        @(posedge pclk);
        wdt_timeout <= 1'b0;
        @(posedge pclk);
        check(pc_sp_clear, 1'b1);
        wait_rst(1'b0);
        rd_chk(LVR_ADDR_STATUS, 32'h00000003);
        power_mode <= LVR_MODE_NORMAL;
        apb(1'b0, 8'h40, 32'h00000000);
        check(err, 1'b1);
        $display("watchdog timeout done");
        pin_bad <= 1'b1;
        wcode_bad <= 1'b1;
        @(posedge pclk);
        pin_bad <= 1'b0;
        wcode_bad <= 1'b0;
        rd_chk(LVR_ADDR_CAUSE, 32'h0000008B);
        apb(1'b1, LVR_ADDR_CAUSE, 32'h00000080);
        rd_chk(LVR_ADDR_CAUSE, 32'h00000080);
        $display("cause flags done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check(wdt_count_en, 1'b0);
        wait_rst(1'b1);
        check(wdt_count_en, 1'b1);
        rd_chk(LVR_ADDR_STATUS, 32'h00000000);
        halt_event <= 1'b1;
        @(posedge pclk);
        halt_event <= 1'b0;
        rd_chk(LVR_ADDR_STATUS, 32'h00000002);
        $display("second power on done");
        stop_test();
    end
endmodule
`default_nettype wire
